// [escr_pkg.sv]
/*
 Package for the event channel source router: register offsets, source
 codes, widths and carrier structs.
 Assumes a plain address/strobe register port of eight-bit data.
*/
package escr_pkg;
    localparam int NUM_CH     = 8;
    localparam int DATA_W     = 8;
    localparam int ADDR_W     = 4;
    localparam int NUM_SRC_IN = 32;

    localparam logic [ADDR_W-1:0] OFF_SUBADDR = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_SUBDATA = 4'h1;

    localparam logic [DATA_W-1:0] RST_CODE    = 8'h00;
    localparam logic [DATA_W-1:0] RST_SUBADDR = 8'h00;

    localparam logic [DATA_W-1:0] CODE_NONE   = 8'h00;
    localparam logic [DATA_W-1:0] CODE_SW     = 8'h01;
    localparam logic [DATA_W-1:0] CODE_TMR0   = 8'h10;
    // Peripheral codes run consecutively from timer 0 out
    localparam logic [DATA_W-1:0] CODE_BASE   = 8'h10;

    // Source vector bit positions
    localparam int SRC_TMR     = 0;
    localparam int SRC_MCT     = 3;
    localparam int SRC_RTC_CLK = 7;
    localparam int SRC_RTC_ALM = 8;
    localparam int SRC_CMP0    = 9;
    localparam int SRC_CMP1    = 10;
    localparam int SRC_CMPWIN  = 11;
    localparam int SRC_PA      = 12;
    localparam int SRC_PC      = 20;
    localparam int SRC_PE      = 24;
    localparam int SRC_USED    = 28;

    // Last member lands at bit 0, so bit n matches source position n
    typedef struct packed {
        logic [6:3] port_e_pin;
        logic [7:4] port_c_pin;
        logic [7:0] port_a_pin;
        logic       comparator_window_detect;
        logic       comparator1_out;
        logic       comparator0_out;
        logic       rtc_alarm;
        logic       rtc_prescaled_clk;
        logic [3:0] mct_out;
        logic [2:0] timer_out;
    } escr_sources_t;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } escr_bus_t;
endpackage

// [escr_code_mem.sv]
/*
 Per-channel source code store: one word per channel, registered read.
 Assumes a single write and a single read port on one clock.
*/
`timescale 1ns/1ns
`default_nettype none
module escr_code_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   rst_in,
    // Write port
    input  wire logic                   we_in,
    input  wire logic [AW-1:0]          waddr_in,
    input  wire logic [WIDTH-1:0]       wdata_in,
    // Registered read port
    input  wire logic [AW-1:0]          raddr_in,
    output logic      [WIDTH-1:0]       rdata_out,
    // All words, for the multiplexers
    output logic      [DEPTH*WIDTH-1:0] words_out
);
    // One register per word keeps each word on a single driver
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_word
            logic [WIDTH-1:0] word_q;
            always_ff @(posedge mclk_in) begin
                if (rst_in) begin
                    word_q <= WIDTH'(escr_pkg::RST_CODE);
                end else if (we_in && waddr_in == AW'(gi)) begin
                    word_q <= wdata_in;
                end
            end
            assign words_out[gi*WIDTH +: WIDTH] = word_q;
        end
    endgenerate

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rdata_out <= '0;
        end else begin
            rdata_out <= words_out[raddr_in*WIDTH +: WIDTH];
        end
    end
endmodule
`default_nettype wire

// [escr_router.sv]
/*
 Event channel source router: eight channels, each a pure multiplexer of
 peripheral and pin sources chosen by a per-channel source code held in
 indirectly addressed subregisters.
 Assumes a plain register port with read data one cycle after the strobe;
 sources and consumers are on-chip logic outside this block.
*/
// Function
// - Eight independent channels, each routing one signal without core or DMA.
// - Routing is combinational, so it keeps working while the core clock stops.
// - A nonzero source code enables its channel; zero leaves it off.
// - An enabled channel follows the one source its code selects; codes 02h-0Fh and 2Ch and up select none and hold it low.
// - Each channel output may feed any number of consumers.
// - Code 01h drives the channel high until another code is written.
// - Pin sources route directly, needing no port alternate function.
// - Sources: timers, multi-channel timer, RTC, comparators, ports A, C, E.
// - No synchronising stage between source and channel output.
// - Subaddress 00h is channel 0; code 10h selects timer 0 out.
`timescale 1ns/1ns
`default_nettype none
module escr_router #(
    parameter int NUM_CH = escr_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic                         mclk_in,
    input  wire logic                         rst_in,
    // Register port
    input  wire logic [escr_pkg::ADDR_W-1:0]  addr_in,
    input  wire logic [escr_pkg::DATA_W-1:0]  wdata_in,
    input  wire logic                         wr_in,
    input  wire logic                         rd_in,
    output logic      [escr_pkg::DATA_W-1:0]  rdata_out,
    // Event sources
    input  wire escr_pkg::escr_sources_t      sources_in,
    // Channel outputs and enables
    output logic      [NUM_CH-1:0]            channel_out,
    output logic      [NUM_CH-1:0]            channel_enabled_out
);
    localparam int DW = escr_pkg::DATA_W;
    localparam int CW = $clog2(NUM_CH);
    localparam int SIW = $clog2(escr_pkg::NUM_SRC_IN);

    escr_pkg::escr_bus_t bus;
    assign bus = '{wr: wr_in, rd: rd_in, addr: addr_in, wdata: wdata_in};

    // Address decode
    wire sel_subaddr = bus.addr == escr_pkg::OFF_SUBADDR;
    wire sel_subdata = bus.addr == escr_pkg::OFF_SUBDATA;
    wire wr_subaddr  = bus.wr && sel_subaddr;
    wire wr_subdata  = bus.wr && sel_subdata;

    logic [DW-1:0] source_subaddress_reg_q;
    logic [DW-1:0] rd_sel_q;
    logic          subaddr_ok_q;

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            source_subaddress_reg_q <= escr_pkg::RST_SUBADDR;
        end else if (wr_subaddr) begin
            source_subaddress_reg_q <= bus.wdata;
        end
    end

    // Subaddress beyond the channel count hits no subregister
    wire           subaddr_ok = source_subaddress_reg_q < DW'(NUM_CH);
    wire [CW-1:0]  ch_idx     = source_subaddress_reg_q[CW-1:0];
    wire           code_we    = wr_subdata && subaddr_ok;

    logic [DW-1:0]        code_rdata;
    logic [NUM_CH*DW-1:0] code_words;

    escr_code_mem #(
        .DEPTH (NUM_CH),
        .WIDTH (DW),
        .AW    (CW)
    ) u_codes (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .we_in     (code_we),
        .waddr_in  (ch_idx),
        .wdata_in  (bus.wdata),
        .raddr_in  (ch_idx),
        .rdata_out (code_rdata),
        .words_out (code_words)
    );

    // Read select: 1 subaddress, 2 subdata, 0 unmapped
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            rd_sel_q     <= '0;
            subaddr_ok_q <= 1'b0;
        end else begin
            rd_sel_q     <= bus.rd ? {6'h00, sel_subdata, sel_subaddr}
                                   : 8'h00;
            subaddr_ok_q <= subaddr_ok;
        end
    end

    logic [DW-1:0] subaddr_rd_q;
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            subaddr_rd_q <= '0;
        end else begin
            subaddr_rd_q <= source_subaddress_reg_q;
        end
    end

    // Read data stand only in the cycle after the strobe
    assign rdata_out = rd_sel_q[0] ? subaddr_rd_q :
                       (rd_sel_q[1] && subaddr_ok_q) ? code_rdata
                       : 8'h00;

    // Flat source vector, indexed by code minus base
    logic [escr_pkg::NUM_SRC_IN-1:0] src_vec;
    assign src_vec = {{(escr_pkg::NUM_SRC_IN-escr_pkg::SRC_USED){1'b0}},
                      sources_in.port_e_pin,
                      sources_in.port_c_pin,
                      sources_in.port_a_pin,
                      sources_in.comparator_window_detect,
                      sources_in.comparator1_out,
                      sources_in.comparator0_out,
                      sources_in.rtc_alarm,
                      sources_in.rtc_prescaled_clk,
                      sources_in.mct_out,
                      sources_in.timer_out};

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CH; gc++) begin : g_ch
            wire [DW-1:0] code    = code_words[gc*DW +: DW];
            wire [DW-1:0] rel     = code - escr_pkg::CODE_BASE;
            wire          in_rng  = code >= escr_pkg::CODE_BASE &&
                                    rel < DW'(escr_pkg::SRC_USED);
            wire          periph  = in_rng &&
                                    src_vec[rel[SIW-1:0]];
            wire          sw      = code == escr_pkg::CODE_SW;
            // Combinational path, alive with the clock stopped
            assign channel_enabled_out[gc] =
                code != escr_pkg::CODE_NONE;
            assign channel_out[gc] = channel_enabled_out[gc] &&
                                     (sw || periph);

            AST_SW_HIGH: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                code == escr_pkg::CODE_SW |-> channel_out[gc])
                else $error("Software code does not drive channel high");
            AST_OFF_LOW: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                code == escr_pkg::CODE_NONE |-> !channel_out[gc]
                && !channel_enabled_out[gc])
                else $error("Disabled channel not low");
            AST_UNASSIGNED_LOW: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                (code > escr_pkg::CODE_SW && code < escr_pkg::CODE_BASE)
                |-> !channel_out[gc])
                else $error("Unassigned code drives channel");
            AST_TMR0_ROUTE: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                code == escr_pkg::CODE_TMR0
                |-> channel_out[gc] == sources_in.timer_out[0])
                else $error("Timer 0 not routed");
            AST_PORTA_ROUTE: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                code == escr_pkg::CODE_BASE + DW'(escr_pkg::SRC_PA)
                |-> channel_out[gc] == sources_in.port_a_pin[0])
                else $error("Port A pin 0 not routed");
            AST_EN_NONZERO: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                code != escr_pkg::CODE_NONE |-> channel_enabled_out[gc])
                else $error("Nonzero code leaves channel disabled");
            AST_HIGH_CODE_LOW: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                code >= escr_pkg::CODE_BASE + DW'(escr_pkg::SRC_USED)
                |-> !channel_out[gc])
                else $error("Code past the last source drives channel");
            AST_PORTE_ROUTE: assert property (@(posedge mclk_in)
                disable iff (rst_in)
                code == escr_pkg::CODE_BASE + DW'(escr_pkg::SRC_USED - 1)
                |-> channel_out[gc] == sources_in.port_e_pin[6])
                else $error("Port E pin 6 not routed");
        end
    endgenerate

    AST_CODE_WRITE: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        code_we |=> code_words[$past(ch_idx)*DW +: DW]
                    == $past(bus.wdata))
        else $error("Source code not stored");
    AST_CODE_READ: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        bus.rd && sel_subdata && subaddr_ok && !bus.wr
        |=> rdata_out == code_words[$past(ch_idx)*DW +: DW])
        else $error("Subdata read mismatch");
    AST_SUBADDR_WRITE: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        wr_subaddr |=> source_subaddress_reg_q == $past(bus.wdata))
        else $error("Subaddress not stored");
    AST_SW_HOLD: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        code_words[DW-1:0] == escr_pkg::CODE_SW && !(code_we && ch_idx == '0)
        |=> channel_out[0])
        else $error("Software assert on channel 0 not held");
    AST_SUBADDR_READ: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        bus.rd && sel_subaddr
        |=> rdata_out == $past(source_subaddress_reg_q))
        else $error("Subaddress read mismatch");
    AST_REFUSED_READ: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        bus.rd && !sel_subaddr && !(sel_subdata && subaddr_ok)
        |=> rdata_out == '0)
        else $error("Refused read not zero");
    AST_RDATA_IDLE: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        !bus.rd |=> rdata_out == '0)
        else $error("Read data outside the read cycle");
    AST_REFUSED_WRITE: assert property (@(posedge mclk_in)
        disable iff (rst_in)
        wr_subdata && !subaddr_ok |=> $stable(code_words))
        else $error("Out of range subaddress wrote a code");
endmodule
`default_nettype wire

// [escr_src_model.sv]
/*
 Model of the peripherals and pins that feed the router's sources.
 Assumes the router samples nothing: levels move just after rising edges.
*/
`timescale 1ns/1ns
`default_nettype none
module escr_src_model #(
    parameter logic [27:0] SEED = 28'h5A3C1E7
) (
    // Clock and reset
    input  wire logic                    mclk_in,
    input  wire logic                    rst_in,
    // Source levels
    output var  escr_pkg::escr_sources_t sources_out
);
    logic [27:0] lfsr_q;

    // A register in the route would lag these updates by a cycle
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            lfsr_q <= SEED;
        end else begin
            lfsr_q <= {lfsr_q[26:0], lfsr_q[27] ^ lfsr_q[24]};
        end
    end

    assign sources_out = lfsr_q;
endmodule
`default_nettype wire

// [escr_router_bench.sv]
/*
 Self-checking bench for the event channel source router.
 Assumes escr_src_model drives the sources and a one-clock register port.
*/
`timescale 1ns/1ns
`default_nettype none
module escr_router_bench;
    logic                    mclk_in;
    logic                    rst_in;
    logic [3:0]              addr_r;
    logic [7:0]              wdata_r;
    logic                    wr_r;
    logic                    rd_r;
    logic [7:0]              rdata;
    logic [7:0]              ch_out;
    logic [7:0]              ch_en;
    escr_pkg::escr_sources_t src;
    logic [7:0]              codes [8];
    logic [7:0]              got;
    int                      err_total;
    int                      tests_run;

    escr_src_model src_m (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .sources_out (src)
    );

    escr_router dut (
        .mclk_in             (mclk_in),
        .rst_in              (rst_in),
        .addr_in             (addr_r),
        .wdata_in            (wdata_r),
        .wr_in               (wr_r),
        .rd_in               (rd_r),
        .rdata_out           (rdata),
        .sources_in          (src),
        .channel_out         (ch_out),
        .channel_enabled_out (ch_en)
    );

    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        addr_r <= a;
        wdata_r <= d;
        wr_r <= 1'b1;
        @(posedge mclk_in);
        wr_r <= 1'b0;
        @(posedge mclk_in);
    endtask

    task automatic bus_rd(input logic [3:0] a);
        addr_r <= a;
        rd_r <= 1'b1;
        @(posedge mclk_in);
        rd_r <= 1'b0;
        #1 got = rdata;
        @(posedge mclk_in);
    endtask

    // Write, then a read on the very next cycle
    task automatic bus_wr_rd(input logic [3:0] a, input logic [7:0] d,
                             input logic [3:0] ra);
        addr_r <= a;
        wdata_r <= d;
        wr_r <= 1'b1;
        @(posedge mclk_in);
        wr_r <= 1'b0;
        addr_r <= ra;
        rd_r <= 1'b1;
        @(posedge mclk_in);
        rd_r <= 1'b0;
        #1 got = rdata;
        @(posedge mclk_in);
    endtask

    function automatic logic exp_ch(input logic [7:0] c,
                                    input logic [27:0] s);
        if (c == escr_pkg::CODE_SW) return 1'b1;
        if (c >= escr_pkg::CODE_BASE &&
            c < escr_pkg::CODE_BASE + 8'(escr_pkg::SRC_USED))
            return s[c - escr_pkg::CODE_BASE];
        return 1'b0;
    endfunction

    // Subaddress first, then subdata, then read back
    task automatic set_code(input logic [2:0] ch, input logic [7:0] c);
        bus_wr(escr_pkg::OFF_SUBADDR, {5'h00, ch});
        bus_wr(escr_pkg::OFF_SUBDATA, c);
        codes[ch] = c;
        bus_rd(escr_pkg::OFF_SUBDATA);
        chk("code", c, got);
    endtask

    // Sampled between edges, after the sources have moved
    task automatic check_all();
        logic [7:0] e;
        logic [7:0] en;
        repeat (3) begin
            @(negedge mclk_in);
            #1;
            for (int k = 0; k < 8; k++) begin
                e[k] = exp_ch(codes[k], src);
                en[k] = codes[k] != 8'h00;
            end
            chk("channel_out", e, ch_out);
            chk("channel_enabled", en, ch_en);
            chk("rdata_idle", 8'h00, rdata);
        end
        @(posedge mclk_in);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #40000;
        err_total++;
        end_sim();
    end

    initial begin
        rst_in = 1'b1;
        addr_r = 4'h0;
        wdata_r = 8'h00;
        wr_r = 1'b0;
        rd_r = 1'b0;
        err_total = 0;
        tests_run = 0;
        foreach (codes[k]) codes[k] = 8'h00;
        got = 8'($urandom(32'h9fca));
        repeat (5) @(posedge mclk_in);
        rst_in <= 1'b0;
        @(posedge mclk_in);
        check_all();
        bus_rd(escr_pkg::OFF_SUBADDR);
        chk("subaddr", escr_pkg::RST_SUBADDR, got);
        set_code(3'h0, escr_pkg::CODE_TMR0);
        check_all();
        for (int c = 0; c < 8'h30; c++) begin
            set_code(c[2:0], c[7:0]);
            check_all();
        end
        set_code(3'h7, 8'hFF);
        check_all();
        repeat (40) begin
            set_code(3'($urandom_range(7, 0)), 8'($urandom_range(8'h2F, 0)));
            check_all();
        end
        bus_wr(4'h7, 8'h5A);
        bus_rd(4'h7);
        chk("unmapped", 8'h00, got);
        bus_wr(escr_pkg::OFF_SUBADDR, 8'h0C);
        bus_rd(escr_pkg::OFF_SUBADDR);
        chk("subaddr", 8'h0C, got);
        bus_wr(escr_pkg::OFF_SUBDATA, 8'h11);
        bus_rd(escr_pkg::OFF_SUBDATA);
        chk("subdata", 8'h00, got);
        check_all();
        // Back-to-back write and read, then a reset in mid-run
        bus_wr_rd(escr_pkg::OFF_SUBADDR, 8'h05, escr_pkg::OFF_SUBADDR);
        chk("subaddr", 8'h05, got);
        bus_wr_rd(escr_pkg::OFF_SUBDATA, escr_pkg::CODE_SW,
                  escr_pkg::OFF_SUBDATA);
        chk("code", escr_pkg::CODE_SW, got);
        codes[5] = escr_pkg::CODE_SW;
        check_all();
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        foreach (codes[k]) codes[k] = 8'h00;
        @(posedge mclk_in);
        check_all();
        bus_rd(escr_pkg::OFF_SUBADDR);
        chk("subaddr", escr_pkg::RST_SUBADDR, got);
        end_sim();
    end
endmodule
`default_nettype wire
